// file: hdl/tcd_ctrl.v
// Control and refresh logic of a three-clock, two-bank DRAM controller
`timescale 1ns/1ps
`include "tcd_defines.vh"

module tcd_ctrl (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        cycleStartReq,
   input  wire        chipSelect,
   input  wire        writeCycle,
   input  wire        bankSelectAddrBit,
   input  wire        singleBankMode,
   input  wire        earlyRowRelease,
   output reg         nextAddressRequestN_ff,
   output reg         memoryReadyOutN_ff,
   output reg         rowStrobeBank0N_ff,
   output reg         rowStrobeBank1N_ff,
   output reg         colStrobeBank0N_ff,
   output reg         colStrobeBank1N_ff,
   output reg         writeEnableN_ff,
   output reg         rowColumnSelect_ff,
   output reg         muxLowOeN_ff,
   output reg  [7:0]  refreshRowOut_ff,
   output reg         refreshRowOeN_ff,
   output reg         phaseOne_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // States of the access state logic, one step per double-rate tick
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ACC  = 3'h1;
   localparam [2:0] ST_REF  = 3'h2;
   localparam [2:0] ST_PRE  = 3'h3;

   // Sequence length of access and refresh in ticks (three bus clocks);
   // the precharge tail gives a same-bank access two bus clocks of rest
   localparam [3:0] ACC_LAST    = `TCD_ACC_LAST;
   localparam [3:0] PRE_LAST    = `TCD_PRE_LAST;

   // Tick of the access sequence at which each event first shows
   localparam [3:0] COLSEL_TICK = `TCD_COLSEL_TICK;
   localparam [3:0] WE_TICK     = `TCD_WE_TICK;
   localparam [3:0] CAS_RD_TICK = `TCD_CAS_RD_TICK;
   localparam [3:0] CAS_WR_TICK = `TCD_CAS_WR_TICK;
   localparam [3:0] NA_TICK     = `TCD_NA_TICK;
   localparam [3:0] RDY_TICK    = `TCD_RDY_TICK;

   // Interval counter value in the last bus clock before the wrap
   localparam [8:0] REF_WRAP    = `TCD_REF_PRESET - 9'h001;

   // State and sequence registers
   reg [2:0]  state_ff;
   reg [2:0]  nxt_state;
   reg [3:0]  seq_ff;
   reg [3:0]  nxt_seq;
   // Refresh bookkeeping
   reg [8:0]  intervalCnt_ff;
   reg        refreshPending_ff;
   reg [7:0]  refreshRow_ff;
   // Access held across the cycle
   reg        curBank_ff;
   reg        curWrite_ff;
   // Arbiter strobes
   reg        startAcc;
   reg        startRef;
   wire       accBank;

   ////////////////////////////////////////////////////////////////////////////
   // Decode shared by the strobe logic: access state at or past a tick
   function accFrom;
      input [2:0] st;
      input [3:0] sq;
      input [3:0] first;
      begin
         accFrom = (st == ST_ACC) && (sq >= first);
      end
   endfunction

   // Decode shared by counter and request latch: last count in phase one
   function atWrap;
      input       ph;
      input [8:0] cnt;
      begin
         atWrap = ph && (cnt == REF_WRAP);
      end
   endfunction

   // Bank seen by the access logic; tied low in single-bank mode
   assign accBank = singleBankMode ? 1'b0 : bankSelectAddrBit;

   ////////////////////////////////////////////////////////////////////////////
   // Phase tracker: bus clock is half the double-rate clock
   // Reset starts in phase one so the first take lines up with a bus clock
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phaseOne_ff <= 1'b1;
      end else begin
         phaseOne_ff <= ~phaseOne_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Refresh interval counter, counted in bus clocks
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         intervalCnt_ff <= 9'h000;
      end else if (phaseOne_ff) begin
         // Wraps on its own, whatever the arbiter is busy with
         if (atWrap(phaseOne_ff, intervalCnt_ff)) begin
            intervalCnt_ff <= 9'h000;
         end else begin
            intervalCnt_ff <= intervalCnt_ff + 9'h001;
         end
      end
   end

   // Pending refresh latch; a new request wins over the clear
   // Held until the arbiter starts it, so a late service still runs once
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         refreshPending_ff <= 1'b0;
      end else if (atWrap(phaseOne_ff, intervalCnt_ff)) begin
         refreshPending_ff <= 1'b1;
      end else if (startRef) begin
         refreshPending_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration: refresh first, accesses only from idle on phase one
   // An access in flight plus its precharge lasts five bus clocks at most,
   // which bounds how long a pending refresh waits for idle
   always @* begin
      startRef = 1'b0;
      startAcc = 1'b0;
      if (state_ff == ST_IDLE && phaseOne_ff) begin
         if (refreshPending_ff) begin
            startRef = 1'b1;
         end else if (cycleStartReq && chipSelect) begin
            startAcc = 1'b1;
         end
      end
   end

   // Next state; illegal codes fall back to idle at once
   // Access and refresh share one six-tick count, then precharge
   always @* begin
      nxt_state = state_ff;
      nxt_seq   = seq_ff + 4'h1;
      case (state_ff)
         ST_IDLE: begin
            nxt_seq = 4'h0;
            if (startRef) begin
               nxt_state = ST_REF;
            end else if (startAcc) begin
               nxt_state = ST_ACC;
            end
         end
         ST_ACC, ST_REF: begin
            if (seq_ff >= ACC_LAST) begin
               nxt_state = ST_PRE;
               nxt_seq   = 4'h0;
            end
         end
         ST_PRE: begin
            if (seq_ff >= PRE_LAST) begin
               nxt_state = ST_IDLE;
               nxt_seq   = 4'h0;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_seq   = 4'h0;
         end
      endcase
   end

   // State register
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         seq_ff   <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         seq_ff   <= nxt_seq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture bank and direction of the access at its start
   // Held here, as the processor may move its address once next-address is seen
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         curBank_ff  <= 1'b0;
         curWrite_ff <= 1'b0;
      end else if (startAcc) begin
         curBank_ff  <= accBank;
         curWrite_ff <= writeCycle;
      end
   end

   // Refresh row counter, advances once each refresh completes
   // Stepped on the last refresh tick, so the next row waits ready
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         refreshRow_ff <= 8'h00;
      end else if (state_ff == ST_REF && seq_ff == ACC_LAST) begin
         refreshRow_ff <= refreshRow_ff + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strobes, select, enables and processor handshake
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rowStrobeBank0N_ff     <= 1'b1;
         rowStrobeBank1N_ff     <= 1'b1;
         colStrobeBank0N_ff     <= 1'b1;
         colStrobeBank1N_ff     <= 1'b1;
         writeEnableN_ff        <= 1'b1;
         rowColumnSelect_ff     <= 1'b1;
         muxLowOeN_ff           <= 1'b0;
         refreshRowOeN_ff       <= 1'b1;
         refreshRowOut_ff       <= 8'h00;
         nextAddressRequestN_ff <= 1'b1;
         memoryReadyOutN_ff     <= 1'b1;
      end else begin
         // Row strobe: access bank, both banks in refresh
         // Both banks open together so one row refreshes in both at once
         if (nxt_state == ST_REF) begin
            rowStrobeBank0N_ff <= 1'b0;
            rowStrobeBank1N_ff <= 1'b0;
         end else if (nxt_state == ST_ACC &&
                      !(earlyRowRelease && nxt_seq == ACC_LAST)) begin
            rowStrobeBank0N_ff <= (state_ff == ST_IDLE) ? accBank : curBank_ff;
            rowStrobeBank1N_ff <= (state_ff == ST_IDLE) ? ~accBank : ~curBank_ff;
         end else begin
            rowStrobeBank0N_ff <= 1'b1;
            rowStrobeBank1N_ff <= 1'b1;
         end

         // Row address during row strobe, column one tick later
         // The late flip holds the row address past the strobe edge
         rowColumnSelect_ff <= !accFrom(nxt_state, nxt_seq, COLSEL_TICK);

         // Column strobe per bank; reads at tick 2, writes at tick 3
         // Writes wait a tick more so the write data has settled
         if (accFrom(nxt_state, nxt_seq, curWrite_ff ? CAS_WR_TICK : CAS_RD_TICK)) begin
            colStrobeBank0N_ff <= curBank_ff;
            colStrobeBank1N_ff <= ~curBank_ff;
         end else begin
            colStrobeBank0N_ff <= 1'b1;
            colStrobeBank1N_ff <= 1'b1;
         end

         // Write enable leads the column strobe by two ticks on writes
         // On reads it stays high, well ahead of the column strobe
         writeEnableN_ff <= !(curWrite_ff && accFrom(nxt_state, nxt_seq, WE_TICK));

         // Refresh floats low mux lines and drives the row counter
         // Upper mux lines stay enabled; the memory ignores them in refresh
         muxLowOeN_ff     <= (nxt_state == ST_REF);
         refreshRowOeN_ff <= !(nxt_state == ST_REF);
         refreshRowOut_ff <= refreshRow_ff;

         // Next-address request at phase one of the second wait state
         // Release on the phase-two edge after ready outlasts the last sample
         if (nxt_state == ST_ACC && nxt_seq == NA_TICK) begin
            nextAddressRequestN_ff <= 1'b0;
         end else if (!memoryReadyOutN_ff && !phaseOne_ff) begin
            nextAddressRequestN_ff <= 1'b1;
         end

         // Ready spans the last bus clock, stable through phase two end
         memoryReadyOutN_ff <= !accFrom(nxt_state, nxt_seq, RDY_TICK);
      end
   end

endmodule

// file: inc/tcd_defines.vh
// Constants for the three-clock DRAM controller control and refresh block
`ifndef TCD_DEFINES_VH
`define TCD_DEFINES_VH
`define TCD_CLK_MHZ        20
`define TCD_REF_PERIOD_NS  15625
`define TCD_REF_CYCLES     (`TCD_CLK_MHZ * `TCD_REF_PERIOD_NS / 1000)
`define TCD_REF_PRESET     9'h138
`define TCD_ROW_W          8
`define TCD_ADDR_W         11
`define TCD_SEQ_W          4
`define TCD_IDLE_LIMIT     5'h12
`define TCD_ACC_LAST       4'h5
`define TCD_PRE_LAST       4'h3
`define TCD_COLSEL_TICK    4'h1
`define TCD_WE_TICK        4'h1
`define TCD_CAS_RD_TICK    4'h2
`define TCD_CAS_WR_TICK    4'h3
`define TCD_NA_TICK        4'h2
`define TCD_RDY_TICK       4'h4
`endif

// file: testbench/tcd_ctrl_sva.sv
// Port checker for the DRAM control and refresh block
`timescale 1ns/1ps
module tcd_ctrl_sva (
   input wire       clk,
   input wire       sys_rst,
   input wire       nextAddressRequestN_ff,
   input wire       memoryReadyOutN_ff,
   input wire       rowStrobeBank0N_ff,
   input wire       rowStrobeBank1N_ff,
   input wire       colStrobeBank0N_ff,
   input wire       colStrobeBank1N_ff,
   input wire       writeEnableN_ff,
   input wire       rowColumnSelect_ff,
   input wire       muxLowOeN_ff,
   input wire [7:0] refreshRowOut_ff,
   input wire       refreshRowOeN_ff
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // One bank open marks an access, both open marks a refresh
   wire       naN   = nextAddressRequestN_ff;
   wire       rdyN  = memoryReadyOutN_ff;
   wire       rowN  = rowStrobeBank0N_ff & rowStrobeBank1N_ff;
   wire       bothN = rowStrobeBank0N_ff | rowStrobeBank1N_ff;
   wire       colN  = colStrobeBank0N_ff & colStrobeBank1N_ff;
   wire [7:0] row   = refreshRowOut_ff;
   sequence acc;
      $fell(rowN) && bothN;
   endsequence
   ////////////////////////////////////////////////////////////
   chk_na_late: assert property (acc |-> ##2 $fell(naN))
      else $error("next-address timing");
   chk_na_hold: assert property ($fell(naN) |-> !naN [*3] ##1 naN)
      else $error("next-address dropped");
   chk_row_column_select_col: assert property (acc |-> rowColumnSelect_ff ##1 !rowColumnSelect_ff)
      else $error("row column select order");
   chk_col_bank: assert property ($fell(colN) |-> colStrobeBank0N_ff == rowStrobeBank0N_ff
      && colStrobeBank1N_ff == rowStrobeBank1N_ff)
      else $error("column strobe bank");
   chk_ready_time: assert property (acc |-> ##4 $fell(rdyN))
      else $error("ready latency");
   chk_ready_width: assert property ($fell(rdyN) |=> !rdyN ##1 rdyN)
      else $error("ready width");
   chk_we_lead: assert property ($fell(writeEnableN_ff) |-> ##2 $fell(colN))
      else $error("write enable lead");
   chk_refresh_drive: assert property (!bothN |-> muxLowOeN_ff && !refreshRowOeN_ff && colN)
      else $error("refresh drive");
   chk_refresh_width: assert property ($fell(bothN) |-> !bothN [*6] ##1 rowN)
      else $error("refresh width");
   chk_row_step: assert property ($changed(row) |-> row == $past(row) + 8'h01)
      else $error("refresh row step");
   cov_access: cover property (acc);
   cov_write: cover property ($fell(writeEnableN_ff));
   cov_refresh: cover property ($fell(bothN));
endmodule
////////////////////////////////////////////////////////////
bind tcd_ctrl tcd_ctrl_sva i_sva (.*);

// file: testbench/tcd_cpu_model.sv
// Processor bus model: one cycle per start pulse
`timescale 1ns/1ps
module tcd_cpu_model (
   input  wire  clk,
   input  wire  start,
   input  wire  wr,
   input  wire  bank,
   input  wire  memoryReadyOutN_ff,
   output logic cycleStartReq = 1'b0,
   output logic writeCycle = 1'b0,
   output logic bankSelectAddrBit = 1'b0,
   output logic done = 1'b0,
   output int   ticks = 0
);
   // Holds the cycle until ready is sampled low, then lets the lines go
   always @(posedge clk) begin
      done <= 1'b0;
      if (cycleStartReq) begin
         ticks <= ticks + 1;
         if (!memoryReadyOutN_ff) begin
            cycleStartReq     <= 1'b0;
            done              <= 1'b1;
            writeCycle        <= ~writeCycle;
            bankSelectAddrBit <= ~bankSelectAddrBit;
         end
      end else if (start) begin
         cycleStartReq     <= 1'b1;
         writeCycle        <= wr;
         bankSelectAddrBit <= bank;
         ticks             <= 0;
      end
   end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the DRAM control and refresh block
`timescale 1ns/1ps
`include "tcd_defines.vh"
module testbench;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       singleBankMode = 1'b0;
   logic       earlyRowRelease = 1'b0;
   logic       csEn = 1'b1;
   logic       start = 1'b0;
   logic       wr = 1'b0;
   logic       bank = 1'b0;
   wire        cycleStartReq, writeCycle, bankSelectAddrBit, done, nextAddressRequestN_ff, memoryReadyOutN_ff;
   wire        rowStrobeBank0N_ff, rowStrobeBank1N_ff, colStrobeBank0N_ff, colStrobeBank1N_ff, writeEnableN_ff;
   wire        rowColumnSelect_ff, muxLowOeN_ff, refreshRowOeN_ff, phaseOne_ff;
   wire  [7:0] refreshRowOut_ff;
   wire        chipSelect = cycleStartReq & csEn;
   int         ticks, cyc = 0, numErrors = 0, nCompared = 0, t0, t1, t2, k;
   tcd_cpu_model i_tcd_cpu_model (.*);
   tcd_ctrl      i_tcd_ctrl (.*);
   ////////////////////////////////////////////////////////////
   always #25 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      nCompared++;
      if (got !== exp) begin
         numErrors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // A wait that ran out ends the run
   task automatic hang(input string what);
      numErrors++;
      $display("MISMATCH %s expected 1 seen 0", what);
      close_out();
   endtask
   // Pulses start with {early, single, bank, write} and waits for the end
   task automatic issue(input logic [3:0] m);
      int n;
      {earlyRowRelease, singleBankMode, bank, wr, start} = {m, 1'b1};
      @(posedge clk) #1 start = 1'b0;
      for (n = 0; n < 80 && !done; n++) @(posedge clk) #1;
      if (!done) hang("done");
   endtask
   ////////////////////////////////////////////////////////////
   // Idle access: latency of 6 or 7 ticks by phase, ready held, the right bank open, or both closed with early release
   task automatic access(input logic [3:0] m);
      repeat (5) @(posedge clk);
      #1 issue(m);
      chk("latency", 1, ticks inside {6, 7});
      chk("ready_low", 0, memoryReadyOutN_ff);
      chk("rows", m[3] ? 2'b11 : (m[2] | !m[1]) ? 2'b10 : 2'b01, {rowStrobeBank1N_ff, rowStrobeBank0N_ff});
   endtask
   // Waits for a refresh start and checks what it drives
   task automatic refresh(input logic [7:0] row, output int at);
      int n;
      for (n = 0; n < 1000 && (rowStrobeBank0N_ff | rowStrobeBank1N_ff); n++) @(posedge clk) #1;
      if (n >= 1000) hang("refresh");
      at = cyc;
      chk("refresh_row", row, refreshRowOut_ff);
      chk("refresh_oe", 2'b10, {muxLowOeN_ff, refreshRowOeN_ff});
   endtask
   // Cycle without chip select is held off until decoded
   task automatic deselect;
      csEn = 1'b0;
      fork
         issue(4'h0);
         begin
            repeat (14) @(posedge clk);
            #1 chk("no_select", 3'b111, {memoryReadyOutN_ff, rowStrobeBank0N_ff, rowStrobeBank1N_ff});
            csEn = 1'b1;
         end
      join
      chk("late_take", 1, ticks > 14);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      #1 chk("reset", 16'h03fb, {nextAddressRequestN_ff, memoryReadyOutN_ff, rowStrobeBank0N_ff, rowStrobeBank1N_ff,
         colStrobeBank0N_ff, colStrobeBank1N_ff, writeEnableN_ff, muxLowOeN_ff, refreshRowOeN_ff, phaseOne_ff});
      sys_rst = 1'b0;
      refresh(8'h00, t0);
      deselect();
      for (k = 0; k < 16; k++) access(k[3:0]);
      refresh(8'h01, t1);
      chk("gap", 2 * `TCD_REF_PRESET, t1 - t0);
      issue(4'h1);
      chk("refresh_first", 1, ticks inside {[8:20]});
      refresh(8'h02, t2);
      chk("gap", 2 * `TCD_REF_PRESET, t2 - t1);
      close_out();
   end
endmodule
